/* test_timer_b_capture_registers.sv */
// Purpose: self-checking bench for the capture/compare timer
// Assumes: byte register port, event channel model, 10 MHz clock
// Notes:   the counter is frozen through debug halt while the periodic, single-shot and pwm tests set up registers
module test_timer_b_capture_registers;
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  logic                  sys_clk = 1'b0;                      // 10 MHz clock
  logic                  rst     = 1'b1;                      // synchronous reset
  logic                  halted  = 1'b1;                      // cpu break state
  logic                  ev_lvl  = 1'b0;                      // level asked of the channel
  logic                  ev_line;                             // channel output
  timer_b_pkg::bus_req_t bus     = '0;                        // register request
  timer_b_pkg::mode_t    mode    = timer_b_pkg::MODE_PERIODIC; // timer mode
  logic [7:0]            rdata;                               // read data
  logic                  snapshot_irq;                                // capture event pulse
  logic                  irq;                                 // interrupt request
  logic                  pwm;                                 // pwm waveform
  int                    error_cnt  = 0;                      // mismatches
  int                    num_checks = 0;                      // comparisons
  int                    snapshot_irq_n     = 0;                      // capture pulses seen
  logic [15:0]           v;                                   // scratch word
  logic [15:0]           w;                                   // scratch word

  always #50 sys_clk = ~sys_clk;

  timer_b_capture_registers u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .bus_i(bus),
    .rdata_o(rdata), .mode_i(mode), .cpu_halted_i(halted), .event_i(ev_line),
    .snapshot_irq_event_o(snapshot_irq), .irq_o(irq), .pwm_o(pwm));
  timer_b_event_src u_src (.sys_clk_i(sys_clk), .level_i(ev_lvl), .event_o(ev_line));

  // a pulse is one cycle long, so counting high samples counts pulses
  always @(posedge sys_clk) begin
    if (snapshot_irq === 1'b1) snapshot_irq_n++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write strobe, held across exactly one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    #1 bus.wr = 1'b0;
  endtask

  // read data stands for the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    #1 bus.rd = 1'b0;
    d = rdata;
  endtask

  // low byte first in both directions, so the shared latch pairs them
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(4'(a + 4'h1), d[15:8]);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(4'(a + 4'h1), d[15:8]);
  endtask

  // hold a channel level for n edges
  task automatic ev_step(input logic lvl, input int n);
    ev_lvl = lvl;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // every mapped place reads zero after reset, unmapped places too except 3
  task automatic t_reset();
    for (int a = 0; a < 16; a++) begin
      if (a != 3) rd_chk(4'(a), 8'h00);
    end
  endtask

  // byte pairing through the shared latch, and direct latch access
  task automatic t_latch();
    wr16(timer_b_pkg::OFS_CNT_LOW, 16'h1234);
    rd_chk(timer_b_pkg::OFS_BYTE_LATCH, 8'h34);
    rd16(timer_b_pkg::OFS_CNT_LOW, v);
    chk(v, 16'h1234);
    wr(timer_b_pkg::OFS_BYTE_LATCH, 8'h77);
    wr(timer_b_pkg::OFS_CNT_HIGH, 8'h56);
    rd16(timer_b_pkg::OFS_CNT_LOW, v);
    chk(v, 16'h5677);
  endtask

  // periodic top match, enable masking, write-one clear, read-only status
  task automatic t_periodic();
    wr16(timer_b_pkg::OFS_CMP_LOW, 16'h0005);
    wr16(timer_b_pkg::OFS_CNT_LOW, 16'h0000);
    wr(timer_b_pkg::OFS_IRQ_ENABLE, 8'h01);
    halted = 1'b0;
    for (int i = 0; i < 40 && irq !== 1'b1; i++) ev_step(1'b0, 1);
    chk({15'h0, irq}, 16'h1);
    rd_chk(timer_b_pkg::OFS_RUN_STATUS, 8'h01);
    wr(timer_b_pkg::OFS_RUN_STATUS, 8'h00);
    rd_chk(timer_b_pkg::OFS_RUN_STATUS, 8'h01);
    halted = 1'b1;
    wr(timer_b_pkg::OFS_IRQ_ENABLE, 8'h00);
    chk({15'h0, irq}, 16'h0);
    wr(timer_b_pkg::OFS_IRQ_ENABLE, 8'h01);
    chk({15'h0, irq}, 16'h1);
    wr(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h00);
    chk({15'h0, irq}, 16'h0);
  endtask

  // rises 12 cycles apart: the second capture holds 11
  task automatic t_freq();
    int n0;
    halted = 1'b0;
    mode = timer_b_pkg::MODE_FREQ;
    wr(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    wr(timer_b_pkg::OFS_EVENT_CTL, 8'h01);
    n0 = snapshot_irq_n;
    ev_step(1'b1, 4);
    ev_step(1'b0, 8);
    ev_step(1'b1, 4);
    ev_step(1'b0, 4);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    rd16(timer_b_pkg::OFS_CMP_LOW, v);
    chk(v, 16'd11);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h00);
    chk(16'(snapshot_irq_n - n0), 16'd2);
    // a register write must beat the increment of the running counter
    wr16(timer_b_pkg::OFS_CNT_LOW, 16'h4000);
    rd16(timer_b_pkg::OFS_CNT_LOW, v);
    chk(v, 16'h4001);
  endtask

  // a 5-cycle pulse of either polarity measures as 4
  task automatic t_pulse();
    mode = timer_b_pkg::MODE_PWIDTH;
    for (int e = 0; e < 2; e++) begin
      wr(timer_b_pkg::OFS_EVENT_CTL, 8'h00);
      ev_step(e[0], 3);
      wr(timer_b_pkg::OFS_EVENT_CTL, {3'h0, e[0], 4'h1});
      ev_step(!e[0], 5);
      ev_step(e[0], 3);
      rd16(timer_b_pkg::OFS_CMP_LOW, v);
      chk(v, 16'd4);
    end
  endtask

  // restart, capture on the fall, stop on the second rise
  task automatic t_combined();
    mode = timer_b_pkg::MODE_FREQ_PW;
    wr(timer_b_pkg::OFS_EVENT_CTL, 8'h00);
    ev_step(1'b0, 3);
    wr(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    wr(timer_b_pkg::OFS_EVENT_CTL, 8'h01);
    ev_step(1'b1, 5);
    ev_step(1'b0, 6);
    ev_step(1'b1, 4);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    rd_chk(timer_b_pkg::OFS_RUN_STATUS, 8'h00);
    rd16(timer_b_pkg::OFS_CNT_LOW, v);
    rd16(timer_b_pkg::OFS_CNT_LOW, w);
    chk(w, v);
    rd16(timer_b_pkg::OFS_CMP_LOW, v);
    chk(v, 16'd4);
  endtask

  // gate off, then debug halt, then halt override
  task automatic t_gate();
    mode = timer_b_pkg::MODE_CAPTURE;
    wr(timer_b_pkg::OFS_EVENT_CTL, 8'h00);
    ev_step(1'b0, 2);
    wr(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    ev_step(1'b1, 3);
    ev_step(1'b0, 3);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h00);
    wr(timer_b_pkg::OFS_EVENT_CTL, 8'h01);
    halted = 1'b1;
    ev_step(1'b1, 3);
    ev_step(1'b0, 3);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h00);
    wr(timer_b_pkg::OFS_DEBUG, 8'h01);
    ev_step(1'b1, 3);
    ev_step(1'b0, 3);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    rd(timer_b_pkg::OFS_CMP_LOW, v[7:0]);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h00);
    wr(timer_b_pkg::OFS_DEBUG, 8'h00);
  endtask

  // let any leftover run expire, then one start edge runs to top and stops
  task automatic t_single();
    mode = timer_b_pkg::MODE_SINGLE;
    wr(timer_b_pkg::OFS_EVENT_CTL, 8'h00);
    wr16(timer_b_pkg::OFS_CNT_LOW, 16'h0000);
    wr16(timer_b_pkg::OFS_CMP_LOW, 16'h0003);
    halted = 1'b0;
    ev_step(1'b0, 10);
    wr(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    rd_chk(timer_b_pkg::OFS_RUN_STATUS, 8'h00);
    wr(timer_b_pkg::OFS_EVENT_CTL, 8'h01);
    ev_step(1'b1, 12);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    rd_chk(timer_b_pkg::OFS_RUN_STATUS, 8'h00);
    rd16(timer_b_pkg::OFS_CNT_LOW, v);
    chk(v, 16'h0000);
  endtask

  // timeout: rise starts, fall stops; top of 3 is left over from single-shot
  task automatic t_timeout();
    mode = timer_b_pkg::MODE_TIMEOUT;
    ev_step(1'b0, 3);
    wr(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    ev_step(1'b1, 4);
    rd_chk(timer_b_pkg::OFS_RUN_STATUS, 8'h01);
    ev_step(1'b0, 4);
    rd_chk(timer_b_pkg::OFS_RUN_STATUS, 8'h00);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
  endtask

  // period 10 from the low byte, 4 high cycles from the high byte
  task automatic t_pwm();
    int n;
    halted = 1'b1;
    mode = timer_b_pkg::MODE_PWM8;
    wr(timer_b_pkg::OFS_CMP_LOW, 8'h09);
    wr(timer_b_pkg::OFS_CMP_HIGH, 8'h04);
    wr16(timer_b_pkg::OFS_CNT_LOW, 16'h0000);
    wr(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    halted = 1'b0;
    // a start edge here must not disturb the waveform
    ev_lvl = 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      if (pwm === 1'b1) n++;
    end
    chk(16'(n), 16'd8);
    rd_chk(timer_b_pkg::OFS_IRQ_FLAGS, 8'h01);
    rd_chk(timer_b_pkg::OFS_CMP_LOW, 8'h09);
    rd_chk(timer_b_pkg::OFS_CMP_HIGH, 8'h04);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // main sequence: reset for three cycles, then each scenario in turn
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_reset();
    t_latch();
    t_periodic();
    t_freq();
    t_pulse();
    t_combined();
    t_gate();
    t_single();
    t_timeout();
    t_pwm();
    report_and_stop();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    repeat (6000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule // test_timer_b_capture_registers

/* timer_b_capture_registers.sv */
// Purpose: 16-bit capture/compare timer with event-driven modes and byte registers
// Assumes: event channel and register port run on sys_clk_i; ctrl fields arrive as inputs
// Notes:   read data appears one cycle after the read strobe
module timer_b_capture_registers (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // register port
  input  wire timer_b_pkg::bus_req_t bus_i,
  output logic [7:0]                 rdata_o,
  // static configuration and debug state
  input  wire timer_b_pkg::mode_t    mode_i,
  input  wire logic                  cpu_halted_i,
  // event channel
  input  wire logic                  event_i,
  output logic                       snapshot_irq_event_o,
  // interrupt and waveform
  output logic                       irq_o,
  output logic                       pwm_o
);
  timer_b_pkg::state_t q;        // registered state
  timer_b_pkg::state_t d;        // next state
  logic                halted;   // frozen by debug break
  logic                ev_rise;  // rising event edge
  logic                ev_fall;  // falling event edge
  logic                cap_edge; // active (capture/start) edge, qualified
  logic                opp_edge; // opposite edge, qualified
  logic                set_flag; // hardware sets the flag this cycle
  logic                clr_flag; // software clears the flag this cycle
  logic                top_hit;  // counter equals 16-bit top
  logic                cap_mode; // one of the capture modes

  ////////////////////////////////////////////////////////////////////////////
  // event qualification
  always_comb begin
    halted   = cpu_halted_i && !q.halt_ovr;
    ev_rise  = event_i && !q.ev_prev;
    ev_fall  = !event_i && q.ev_prev;
    // edge select swaps which polarity is the active one
    cap_edge = q.gate && !halted && (q.edge_sel ? ev_fall : ev_rise);
    opp_edge = q.gate && !halted && (q.edge_sel ? ev_rise : ev_fall);
    top_hit  = (q.cnt == q.compare_snapshot);
    cap_mode = (mode_i == timer_b_pkg::MODE_CAPTURE) || (mode_i == timer_b_pkg::MODE_FREQ) ||
               (mode_i == timer_b_pkg::MODE_PWIDTH) || (mode_i == timer_b_pkg::MODE_FREQ_PW);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: counting engine first, then register port on top of it
  always_comb begin
    d            = q;
    d.ev_prev    = event_i;
    set_flag     = 1'b0;
    clr_flag     = 1'b0;
    // while halted nothing moves; the edge history still follows the input
    if (!halted) begin
      case (mode_i)
        timer_b_pkg::MODE_PERIODIC: begin
          d.run = 1'b1;
          if (top_hit) begin
            set_flag = 1'b1;
            d.cnt    = timer_b_pkg::RST_WORD;
          end else begin
            d.cnt = q.cnt + 16'h0001;
          end
        end
        timer_b_pkg::MODE_TIMEOUT: begin
          // stop edge is checked last so a tie leaves the counter stopped
          if (cap_edge) d.run = 1'b1;
          if (opp_edge) d.run = 1'b0;
          if (q.run) begin
            if (top_hit) begin
              set_flag = 1'b1;
              d.cnt    = timer_b_pkg::RST_WORD;
            end else begin
              d.cnt = q.cnt + 16'h0001;
            end
          end
        end
        timer_b_pkg::MODE_CAPTURE: begin
          d.run = 1'b1;
          d.cnt = q.cnt + 16'h0001;
          if (cap_edge) begin
            d.compare_snapshot   = q.cnt;
            set_flag = 1'b1;
          end
        end
        timer_b_pkg::MODE_FREQ: begin
          d.run = 1'b1;
          if (cap_edge) begin
            d.compare_snapshot   = q.cnt;
            d.cnt    = timer_b_pkg::RST_WORD;
            set_flag = 1'b1;
          end else begin
            d.cnt = q.cnt + 16'h0001;
          end
        end
        timer_b_pkg::MODE_PWIDTH: begin
          d.run = 1'b1;
          // start-polarity edge restarts the count, the other edge captures it
          if (cap_edge) begin
            d.cnt = timer_b_pkg::RST_WORD;
          end else begin
            d.cnt = q.cnt + 16'h0001;
          end
          if (opp_edge) begin
            d.compare_snapshot   = q.cnt;
            set_flag = 1'b1;
          end
        end
        timer_b_pkg::MODE_FREQ_PW: begin
          if (q.run) d.cnt = q.cnt + 16'h0001;
          case (q.phase)
            timer_b_pkg::FP_IDLE: begin
              if (cap_edge) begin
                d.cnt   = timer_b_pkg::RST_WORD;
                d.run   = 1'b1;
                d.phase = timer_b_pkg::FP_COUNT;
              end
            end
            timer_b_pkg::FP_COUNT: begin
              if (opp_edge) begin
                d.compare_snapshot  = q.cnt;
                d.phase = timer_b_pkg::FP_CAPTURED;
              end
            end
            timer_b_pkg::FP_CAPTURED: begin
              if (cap_edge) begin
                d.run    = 1'b0;
                d.cnt    = q.cnt;
                set_flag = 1'b1;
                d.phase  = timer_b_pkg::FP_IDLE;
              end
            end
            default: d.phase = timer_b_pkg::FP_IDLE;
          endcase
        end
        timer_b_pkg::MODE_SINGLE: begin
          if (q.run) begin
            if (top_hit) begin
              set_flag = 1'b1;
              d.run    = 1'b0;
              d.cnt    = timer_b_pkg::RST_WORD;
            end else begin
              d.cnt = q.cnt + 16'h0001;
            end
          end else if (cap_edge) begin
            d.run = 1'b1;
          end
        end
        timer_b_pkg::MODE_PWM8: begin
          // events are ignored here; only the low byte counts
          d.run = 1'b1;
          if (q.cnt[7:0] == q.compare_snapshot[7:0]) begin
            set_flag = 1'b1;
            d.cnt    = timer_b_pkg::RST_WORD;
          end else begin
            d.cnt = {8'h00, q.cnt[7:0] + 8'h01};
          end
        end
        default: d.run = 1'b0;
      endcase
      if (mode_i != timer_b_pkg::MODE_FREQ_PW) d.phase = timer_b_pkg::FP_IDLE;
    end

    // register port writes; they come after the engine so they win
    if (bus_i.wr) begin
      case (bus_i.addr)
        timer_b_pkg::OFS_EVENT_CTL: begin
          d.gate     = bus_i.wdata[timer_b_pkg::BIT_GATE];
          d.edge_sel = bus_i.wdata[timer_b_pkg::BIT_EDGE];
        end
        timer_b_pkg::OFS_IRQ_ENABLE: d.irq_en = bus_i.wdata[timer_b_pkg::BIT_SNAP];
        timer_b_pkg::OFS_IRQ_FLAGS:  clr_flag = bus_i.wdata[timer_b_pkg::BIT_SNAP];
        timer_b_pkg::OFS_DEBUG:      d.halt_ovr = bus_i.wdata[timer_b_pkg::BIT_HOVR];
        timer_b_pkg::OFS_BYTE_LATCH: d.temp = bus_i.wdata;
        timer_b_pkg::OFS_CNT_LOW:    d.temp = bus_i.wdata;
        timer_b_pkg::OFS_CNT_HIGH:   d.cnt = {bus_i.wdata, q.temp};
        timer_b_pkg::OFS_CMP_LOW: begin
          // pwm8 bytes are independent, so no latching there
          if (mode_i == timer_b_pkg::MODE_PWM8) d.compare_snapshot[7:0] = bus_i.wdata;
          else d.temp = bus_i.wdata;
        end
        timer_b_pkg::OFS_CMP_HIGH: begin
          if (mode_i == timer_b_pkg::MODE_PWM8) d.compare_snapshot[15:8] = bus_i.wdata;
          else d.compare_snapshot = {bus_i.wdata, q.temp};
        end
        default: d.temp = q.temp; // status and unmapped writes are dropped
      endcase
    end

    // register port reads; a low byte read parks the high byte in the latch, except a compare read in pwm8
    d.rdata = timer_b_pkg::RST_BYTE;
    if (bus_i.rd) begin
      case (bus_i.addr)
        timer_b_pkg::OFS_EVENT_CTL: begin
          d.rdata[timer_b_pkg::BIT_GATE] = q.gate;
          d.rdata[timer_b_pkg::BIT_EDGE] = q.edge_sel;
        end
        timer_b_pkg::OFS_IRQ_ENABLE: d.rdata[timer_b_pkg::BIT_SNAP] = q.irq_en;
        timer_b_pkg::OFS_IRQ_FLAGS:  d.rdata[timer_b_pkg::BIT_SNAP] = q.flag;
        timer_b_pkg::OFS_RUN_STATUS: d.rdata[timer_b_pkg::BIT_RUN]  = q.run;
        timer_b_pkg::OFS_DEBUG:      d.rdata[timer_b_pkg::BIT_HOVR] = q.halt_ovr;
        timer_b_pkg::OFS_BYTE_LATCH: d.rdata = q.temp;
        timer_b_pkg::OFS_CNT_LOW: begin
          d.rdata = q.cnt[7:0];
          if (!bus_i.wr) d.temp = q.cnt[15:8];
        end
        timer_b_pkg::OFS_CNT_HIGH: d.rdata = q.temp;
        timer_b_pkg::OFS_CMP_LOW: begin
          d.rdata = q.compare_snapshot[7:0];
          if (mode_i != timer_b_pkg::MODE_PWM8 && !bus_i.wr) d.temp = q.compare_snapshot[15:8];
          if (cap_mode) clr_flag = 1'b1;
        end
        timer_b_pkg::OFS_CMP_HIGH: begin
          d.rdata = (mode_i == timer_b_pkg::MODE_PWM8) ? q.compare_snapshot[15:8] : q.temp;
        end
        default: d.rdata = timer_b_pkg::RST_BYTE; // unmapped reads as zero
      endcase
    end

    // a set in the same cycle as a clear is kept
    d.flag       = (q.flag && !clr_flag) || set_flag;
    d.snapshot_irq_pulse = set_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_o      = q.rdata;
  assign snapshot_irq_event_o = q.snapshot_irq_pulse;
  assign irq_o        = q.flag && q.irq_en;
  assign pwm_o        = (mode_i == timer_b_pkg::MODE_PWM8) && q.run &&
                        (q.cnt[7:0] < q.compare_snapshot[15:8]);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_set_beats_clear: assert property (set_flag && clr_flag |=> q.flag)
    else $error("flag lost when set and clear collide");
  a_w1c_clears: assert property (bus_i.wr && bus_i.addr == timer_b_pkg::OFS_IRQ_FLAGS &&
      bus_i.wdata[0] && !set_flag |=> !q.flag)
    else $error("write one did not clear flag");
  a_capture_read_clr: assert property (bus_i.rd && bus_i.addr == timer_b_pkg::OFS_CMP_LOW &&
      cap_mode && !set_flag |=> !q.flag)
    else $error("capture read did not clear flag");
  a_irq_follows: assert property (set_flag && q.irq_en && !bus_i.wr |=> irq_o ##1 (irq_o || !q.flag))
    else $error("interrupt request not raised with flag");
  a_event_pulse: assert property (set_flag |=> snapshot_irq_event_o ##1 (snapshot_irq_event_o == $past(set_flag)))
    else $error("capture event pulse wrong");
  a_cnt_write_prio: assert property (bus_i.wr && bus_i.addr == timer_b_pkg::OFS_CNT_HIGH
      |=> q.cnt == {$past(bus_i.wdata), $past(q.temp)})
    else $error("counter write lost to count update");
  a_freq_restart: assert property (mode_i == timer_b_pkg::MODE_FREQ && cap_edge && !bus_i.wr
      |=> q.cnt == 16'h0000 && q.flag && q.compare_snapshot == $past(q.cnt))
    else $error("frequency capture wrong");
  a_gate_blocks: assert property (!q.gate && mode_i == timer_b_pkg::MODE_CAPTURE && !bus_i.wr
      |=> $stable(q.compare_snapshot))
    else $error("event acted while gate off");
  a_debug_freeze: assert property (halted && !bus_i.wr |=> $stable(q.cnt) && $stable(q.run))
    else $error("timer moved while halted");
  a_periodic_top: assert property (mode_i == timer_b_pkg::MODE_PERIODIC && !halted && top_hit &&
      !bus_i.wr |=> q.flag && q.cnt == 16'h0000)
    else $error("periodic top missed");
  a_status_read: assert property (bus_i.rd && bus_i.addr == timer_b_pkg::OFS_RUN_STATUS
      |=> rdata_o == {7'h00, $past(q.run)})
    else $error("status does not show running");
endmodule // timer_b_capture_registers

/* timer_b_event_src.sv */
// Purpose: behavioural model of the event channel feeding the capture timer
// Assumes: the channel is synchronous to sys_clk_i
// Notes:   a requested level is launched on the next edge, so it always lasts whole cycles
module timer_b_event_src (
  // clock
  input  wire logic sys_clk_i,
  // requested level from the bench
  input  wire logic level_i,
  // event line towards the timer
  output logic      event_o
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // start low so the timer never sees an unknown level at time zero
  initial event_o = 1'b0;

  // registered launch: a level shorter than one cycle cannot be produced
  always @(posedge sys_clk_i) begin
    event_o <= level_i;
  end
endmodule // timer_b_event_src

/* timer_b_pkg.sv */
// Purpose: shared constants and types for the timer_b capture/compare block
// Assumes: byte-wide register port on the peripheral clock
// Notes:   offsets are byte addresses on the register port
package timer_b_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register offsets (4-bit byte address space)
  localparam logic [3:0] OFS_EVENT_CTL  = 4'h4; // event_input_control
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h5; // irq_enable
  localparam logic [3:0] OFS_IRQ_FLAGS  = 4'h6; // irq_flags
  localparam logic [3:0] OFS_RUN_STATUS = 4'h7; // run_status
  localparam logic [3:0] OFS_DEBUG      = 4'h8; // debug_behaviour
  localparam logic [3:0] OFS_BYTE_LATCH = 4'h9; // byte_latch
  localparam logic [3:0] OFS_CNT_LOW    = 4'ha; // counter_value low byte
  localparam logic [3:0] OFS_CNT_HIGH   = 4'hb; // counter_value high byte
  localparam logic [3:0] OFS_CMP_LOW    = 4'hc; // compare_snapshot low byte
  localparam logic [3:0] OFS_CMP_HIGH   = 4'hd; // compare_snapshot high byte

  // field positions
  localparam int BIT_GATE = 0;  // event_input_gate in event_input_control
  localparam int BIT_EDGE = 4;  // edge select in event_input_control
  localparam int BIT_SNAP = 0;  // snapshot_irq in enable and flag registers
  localparam int BIT_RUN  = 0;  // running bit in run_status
  localparam int BIT_HOVR = 0;  // halt_override in debug_behaviour

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  // timer_mode_select encodings
  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT  = 3'h1,
    MODE_CAPTURE  = 3'h2,
    MODE_FREQ     = 3'h3,
    MODE_PWIDTH   = 3'h4,
    MODE_FREQ_PW  = 3'h5,
    MODE_SINGLE   = 3'h6,
    MODE_PWM8     = 3'h7
  } mode_t;

  // phase of the combined frequency and pulse-width measurement
  typedef enum logic [1:0] {
    FP_IDLE,
    FP_COUNT,
    FP_CAPTURED
  } fp_phase_t;

  // one register port request
  typedef struct packed {
    logic       wr;    // write strobe
    logic       rd;    // read strobe
    logic [3:0] addr;  // byte address
    logic [7:0] wdata; // write data
  } bus_req_t;

  // whole state of the timer
  typedef struct packed {
    logic [15:0] cnt;        // counter_value
    logic [15:0] compare_snapshot;       // compare_snapshot
    logic [7:0]  temp;       // byte_latch
    logic        irq_en;     // snapshot_irq enable
    logic        flag;       // snapshot_irq flag
    logic        halt_ovr;   // halt_override
    logic        gate;       // event_input_gate
    logic        edge_sel;   // edge select
    logic        run;        // counter running
    fp_phase_t   phase;      // combined-mode phase
    logic        ev_prev;    // last event level for edge detection
    logic        snapshot_irq_pulse; // one-cycle capture event
    logic [7:0]  rdata;      // read data
  } state_t;
endpackage : timer_b_pkg
